//--- rtl/cu_uart.sv
// Serial transmitter and receiver with register file on a slave port.
// Assumes the slave port, rx_serial and cts_n come from outside; the
// pins run through external level shifters.
`timescale 1ns/1ps

module cu_uart
    import cu_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        ce,
    // Register slave port
    input  wire cu_req_t     bus_req,
    output logic [15:0]      bus_rdata,
    output logic             bus_rd_avail,
    output logic             bus_wr_ready,
    output logic             bus_eop,
    output logic             irq,
    // Serial pins
    input  wire logic        rx_serial,
    output logic             tx_serial,
    input  wire logic        cts_n,
    output logic             rts_n
);

    // =========================================================
    // Helpers
    function automatic logic par_of(input logic [DATA_W-1:0] d);
        par_of = (PARITY == PAR_ODD) ? ~(^d) : ^d;
    endfunction

    function automatic logic hit(input logic [2:0] a);
        hit = (bus_req.addr == a);
    endfunction

    // =========================================================
    // Register decode
    logic              rd_rx, wr_tx, wr_stat, wr_ctl, wr_div, wr_eopc;
    logic [15:0]       ctl_q, div_q, eopc_q, baud_div, stat;
    logic [DATA_W-1:0] rx_hold_q, rx_sh_q, tx_sh_q;
    logic              rrdy_q, roe_q, pe_q, fe_q, brk_q, toe_q;
    logic              eop_q, dcts_q, cts_q;
    logic              rx_done, rx_pe, rx_fe, rx_brk;

    assign rd_rx   = bus_req.rd && hit(A_RXDATA);
    assign wr_tx   = bus_req.wr && hit(A_TXDATA);
    assign wr_stat = bus_req.wr && hit(A_STATUS);
    assign wr_ctl  = bus_req.wr && hit(A_CONTROL);
    assign wr_div  = bus_req.wr && hit(A_DIVISOR);
    assign wr_eopc = bus_req.wr && hit(A_EOPCHAR);

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ctl_q  <= CTL_RST;
            div_q  <= FIXED_DIV;
            eopc_q <= 16'h0000;
        end else if (ce) begin
            if (wr_ctl)
                ctl_q <= bus_req.wdata;
            if (wr_div && HAS_DIV_REG)
                div_q <= bus_req.wdata;
            if (wr_eopc && HAS_EOP)
                eopc_q <= 16'(bus_req.wdata[DATA_W-1:0]);
        end
    end

    // Fixed divider when the register is not built
    assign baud_div = HAS_DIV_REG ? div_q : FIXED_DIV;

    // =========================================================
    // Transmit buffer, two entries
    logic [DATA_W-1:0] txb_q [TXB_DEPTH];
    logic              txb_wp_q, txb_rp_q;
    logic [1:0]        txb_cnt_q;
    logic              txb_push, txb_pop, tx_ovr;
    cu_st_t            tx_st_q;

    assign txb_push = wr_tx && (txb_cnt_q != TXB_FULL);
    assign tx_ovr   = wr_tx && (txb_cnt_q == TXB_FULL);
    assign txb_pop  = (tx_st_q == LS_IDLE) && (txb_cnt_q != 2'h0);

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            txb_wp_q  <= 1'b0;
            txb_rp_q  <= 1'b0;
            txb_cnt_q <= 2'h0;
        end else if (ce) begin
            if (txb_push) begin
                txb_q[txb_wp_q] <= bus_req.wdata[DATA_W-1:0];
                txb_wp_q        <= ~txb_wp_q;
            end
            if (txb_pop)
                txb_rp_q <= ~txb_rp_q;
            txb_cnt_q <= txb_cnt_q + 2'(txb_push) - 2'(txb_pop);
        end
    end

    // =========================================================
    // Transmitter
    logic [15:0] tx_cnt_q;
    logic [3:0]  tx_bit_q;
    logic [1:0]  tx_stop_q;
    logic        tx_par_q, tx_out_q, tx_tick;

    assign tx_tick = (tx_cnt_q == 16'h0000);

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tx_st_q   <= LS_IDLE;
            tx_cnt_q  <= 16'h0000;
            tx_bit_q  <= 4'h0;
            tx_stop_q <= 2'h0;
            tx_sh_q   <= '0;
            tx_par_q  <= 1'b0;
            tx_out_q  <= LINE_MARK;
        end else if (ce) begin
            tx_cnt_q <= tx_tick ? baud_div : tx_cnt_q - 16'h0001;
            case (tx_st_q)
                LS_IDLE: begin
                    tx_out_q <= LINE_MARK;
                    if (txb_pop) begin
                        tx_sh_q  <= txb_q[txb_rp_q];
                        tx_par_q <= par_of(txb_q[txb_rp_q]);
                        tx_out_q <= LINE_SPACE;
                        tx_cnt_q <= baud_div;
                        tx_st_q  <= LS_START;
                    end
                end
                LS_START: begin
                    if (tx_tick) begin
                        tx_out_q <= tx_sh_q[0];
                        tx_bit_q <= 4'h0;
                        tx_st_q  <= LS_DATA;
                    end
                end
                LS_DATA: begin
                    if (tx_tick) begin
                        tx_sh_q  <= tx_sh_q >> 1;
                        tx_bit_q <= tx_bit_q + 4'h1;
                        tx_out_q <= tx_sh_q[1];
                        if (tx_bit_q == LAST_BIT) begin
                            tx_stop_q <= 2'h0;
                            if (PARITY != PAR_NONE) begin
                                tx_out_q <= tx_par_q;
                                tx_st_q  <= LS_PAR;
                            end else begin
                                tx_out_q <= LINE_MARK;
                                tx_st_q  <= LS_STOP;
                            end
                        end
                    end
                end
                LS_PAR: begin
                    if (tx_tick) begin
                        tx_out_q <= LINE_MARK;
                        tx_st_q  <= LS_STOP;
                    end
                end
                LS_STOP: begin
                    if (tx_tick) begin
                        tx_stop_q <= tx_stop_q + 2'h1;
                        if (tx_stop_q == LAST_STOP)
                            tx_st_q <= LS_IDLE;
                    end
                end
                default: tx_st_q <= LS_IDLE;
            endcase
        end
    end

    assign tx_serial = tx_out_q;

    // =========================================================
    // Pin synchronisers, change taken when stages two and three agree
    logic [2:0] rx_sy_q, cts_sy_q;
    logic       rx_line_q;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rx_sy_q   <= {3{LINE_MARK}};
            cts_sy_q  <= 3'h7;
            rx_line_q <= LINE_MARK;
            cts_q     <= 1'b0;
        end else if (ce) begin
            rx_sy_q  <= {rx_sy_q[1:0], rx_serial};
            cts_sy_q <= {cts_sy_q[1:0], cts_n};
            if (rx_sy_q[1] == rx_sy_q[2])
                rx_line_q <= rx_sy_q[2];
            if (cts_sy_q[1] == cts_sy_q[2] && HAS_FLOW)
                cts_q <= ~cts_sy_q[2];
        end
    end

    // =========================================================
    // Receiver
    cu_st_t      rx_st_q;
    logic [15:0] rx_cnt_q;
    logic [3:0]  rx_bit_q;
    logic        rx_par_q, rx_allsp_q, rx_tick;

    assign rx_tick = (rx_cnt_q == 16'h0000);
    assign rx_done = (rx_st_q == LS_STOP) && rx_tick;
    assign rx_fe   = rx_line_q != LINE_MARK;
    assign rx_brk  = rx_allsp_q && (rx_line_q == LINE_SPACE);
    assign rx_pe   = (PARITY != PAR_NONE)
                   && (rx_par_q != par_of(rx_sh_q));

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rx_st_q    <= LS_IDLE;
            rx_cnt_q   <= 16'h0000;
            rx_bit_q   <= 4'h0;
            rx_sh_q    <= '0;
            rx_par_q   <= 1'b0;
            rx_allsp_q <= 1'b0;
        end else if (ce) begin
            rx_cnt_q <= rx_tick ? baud_div : rx_cnt_q - 16'h0001;
            case (rx_st_q)
                LS_IDLE: begin
                    if (rx_line_q == LINE_SPACE) begin
                        rx_cnt_q <= baud_div >> 1;
                        rx_st_q  <= LS_START;
                    end
                end
                LS_START: begin
                    if (rx_tick) begin
                        rx_bit_q   <= 4'h0;
                        rx_allsp_q <= 1'b1;
                        rx_st_q    <= (rx_line_q == LINE_SPACE)
                                    ? LS_DATA : LS_IDLE;
                    end
                end
                LS_DATA: begin
                    if (rx_tick) begin
                        rx_sh_q    <= {rx_line_q, rx_sh_q[DATA_W-1:1]};
                        rx_bit_q   <= rx_bit_q + 4'h1;
                        rx_allsp_q <= rx_allsp_q
                                    && (rx_line_q == LINE_SPACE);
                        if (rx_bit_q == LAST_BIT)
                            rx_st_q <= (PARITY != PAR_NONE)
                                     ? LS_PAR : LS_STOP;
                    end
                end
                LS_PAR: begin
                    if (rx_tick) begin
                        rx_par_q   <= rx_line_q;
                        rx_allsp_q <= rx_allsp_q
                                    && (rx_line_q == LINE_SPACE);
                        rx_st_q    <= LS_STOP;
                    end
                end
                LS_STOP: begin
                    if (rx_tick)
                        rx_st_q <= LS_IDLE;
                end
                default: rx_st_q <= LS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn)
            rx_hold_q <= '0;
        else if (ce && rx_done)
            rx_hold_q <= rx_sh_q;
    end

    // =========================================================
    // Status flags, set wins over clear
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rrdy_q <= 1'b0;
            roe_q  <= 1'b0;
            pe_q   <= 1'b0;
            fe_q   <= 1'b0;
            brk_q  <= 1'b0;
            toe_q  <= 1'b0;
            eop_q  <= 1'b0;
            dcts_q <= 1'b0;
        end else if (ce) begin
            if (rd_rx)
                rrdy_q <= 1'b0;
            if (wr_stat) begin
                roe_q  <= 1'b0;
                pe_q   <= 1'b0;
                fe_q   <= 1'b0;
                brk_q  <= 1'b0;
                toe_q  <= 1'b0;
                eop_q  <= 1'b0;
                dcts_q <= 1'b0;
            end
            if (rx_done) begin
                rrdy_q <= 1'b1;
                if (rrdy_q && !rd_rx)
                    roe_q <= 1'b1;
                if (rx_pe)
                    pe_q <= 1'b1;
                if (rx_fe)
                    fe_q <= 1'b1;
                if (rx_brk)
                    brk_q <= 1'b1;
                if (HAS_EOP && rx_sh_q == eopc_q[DATA_W-1:0])
                    eop_q <= 1'b1;
            end
            if (tx_ovr)
                toe_q <= 1'b1;
            if (txb_push && HAS_EOP
                && bus_req.wdata[DATA_W-1:0] == eopc_q[DATA_W-1:0])
                eop_q <= 1'b1;
            if (HAS_FLOW && cts_sy_q[1] == cts_sy_q[2]
                && cts_q == cts_sy_q[2])
                dcts_q <= 1'b1;
        end
    end

    always_comb begin
        stat          = 16'h0000;
        stat[SB_PE]   = pe_q;
        stat[SB_FE]   = fe_q;
        stat[SB_BRK]  = brk_q;
        stat[SB_ROE]  = roe_q;
        stat[SB_TOE]  = toe_q;
        stat[SB_TMT]  = (tx_st_q == LS_IDLE);
        stat[SB_TRDY] = bus_wr_ready;
        stat[SB_RRDY] = rrdy_q;
        stat[SB_E]    = pe_q | fe_q | brk_q | roe_q | toe_q;
        stat[SB_DCTS] = dcts_q;
        stat[SB_CTS]  = cts_q;
        stat[SB_EOP]  = eop_q;
    end

    // =========================================================
    // Read data, one cycle after the request
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            bus_rdata <= 16'h0000;
        end else if (ce && bus_req.rd) begin
            case (bus_req.addr)
                A_RXDATA:  bus_rdata <= 16'(rx_hold_q);
                A_STATUS:  bus_rdata <= stat;
                A_CONTROL: bus_rdata <= ctl_q;
                A_DIVISOR: bus_rdata <= baud_div;
                A_EOPCHAR: bus_rdata <= eopc_q;
                default:   bus_rdata <= 16'h0000;
            endcase
        end
    end

    assign bus_wr_ready = (txb_cnt_q != TXB_FULL);
    assign bus_rd_avail = rrdy_q;
    assign bus_eop      = eop_q;
    assign irq          = |(stat & ctl_q & IE_MASK);
    assign rts_n        = HAS_FLOW ? ~ctl_q[CB_RTS] : 1'b1;

    // =========================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    chk_rrdy_read_clr: assert property (
        ce && rd_rx && !rx_done |=> !rrdy_q)
        else $error("read of receive data left available set");
    chk_roe_on_full: assert property (
        ce && rx_done && rrdy_q && !rd_rx |=> roe_q && rrdy_q)
        else $error("receive overrun not flagged");
    chk_toe_on_full: assert property (
        ce && wr_tx && !bus_wr_ready |=> toe_q)
        else $error("transmit overrun not flagged");
    chk_tx_start_bit: assert property (
        ce && tx_st_q == LS_IDLE && txb_cnt_q != 2'h0
        |=> tx_serial == LINE_SPACE && tx_st_q == LS_START)
        else $error("start bit not driven on load");
    chk_tx_idle_mark: assert property (
        tx_st_q == LS_IDLE |-> tx_serial == LINE_MARK)
        else $error("idle line not at mark");
    chk_hold_stable: assert property (
        !(ce && rx_done) |=> $stable(rx_hold_q))
        else $error("receive holding changed without a character");
    chk_rrdy_irq: assert property (
        ce && rx_done && ctl_q[SB_RRDY] ##1 ctl_q[SB_RRDY] |-> irq)
        else $error("no interrupt for received character");
    chk_par_err: assert property (
        ce && rx_done && rx_pe |=> pe_q && stat[SB_E])
        else $error("parity error not flagged");

    cov_rx_char: cover property (ce && rx_done ##1 rrdy_q);
    cov_tx_busy_wr: cover property (ce && txb_push && tx_st_q != LS_IDLE);
    cov_eop_seen: cover property ($rose(eop_q));

endmodule

//--- pkg/cu_pkg.sv
// Constants, build options and carrier types of the UART core.
// Assumes one system clock; all options are fixed at build time.
package cu_pkg;

    // =========================================================
    // Build options
    typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} cu_par_t;
    localparam int      DATA_W      = 8;
    localparam cu_par_t PARITY      = PAR_EVEN;
    localparam int      STOP_BITS   = 1;
    localparam bit      HAS_DIV_REG = 1'b1;
    localparam bit      HAS_FLOW    = 1'b1;
    localparam bit      HAS_EOP     = 1'b1;

    // =========================================================
    // Baud timing
    localparam int          CLK_HZ    = 125_000_000;
    localparam int          BAUD_DEF  = 115_200;
    localparam logic [15:0] FIXED_DIV =
        16'((CLK_HZ + BAUD_DEF / 2) / BAUD_DEF);

    // =========================================================
    // Register map (word index on the slave port)
    localparam int         ADDR_W    = 3;
    localparam logic [2:0] A_RXDATA  = 3'h0;
    localparam logic [2:0] A_TXDATA  = 3'h1;
    localparam logic [2:0] A_STATUS  = 3'h2;
    localparam logic [2:0] A_CONTROL = 3'h3;
    localparam logic [2:0] A_DIVISOR = 3'h4;
    localparam logic [2:0] A_EOPCHAR = 3'h5;

    // Status bits; control holds enables at the same places, except bit 11, which holds RTS and no CTS enable
    localparam int SB_PE   = 0;
    localparam int SB_FE   = 1;
    localparam int SB_BRK  = 2;
    localparam int SB_ROE  = 3;
    localparam int SB_TOE  = 4;
    localparam int SB_TMT  = 5;
    localparam int SB_TRDY = 6;
    localparam int SB_RRDY = 7;
    localparam int SB_E    = 8;
    localparam int SB_DCTS = 10;
    localparam int SB_CTS  = 11;
    localparam int SB_EOP  = 12;
    localparam int CB_RTS  = 11;
    localparam logic [15:0] IE_MASK  = 16'h15FF;
    localparam logic [15:0] CTL_RST  = 16'h0000;
    localparam logic [15:0] CLR_MASK = 16'h141F;

    // =========================================================
    // Line levels
    localparam logic LINE_MARK  = 1'b0;
    localparam logic LINE_SPACE = 1'b1;

    localparam int         TXB_DEPTH = 2;
    localparam logic [1:0] TXB_FULL  = 2'h2;
    localparam logic [3:0] LAST_BIT  = 4'(DATA_W - 1);
    localparam logic [1:0] LAST_STOP = 2'(STOP_BITS - 1);

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [15:0]       wdata;
    } cu_req_t;

    typedef enum logic [2:0] {
        LS_IDLE, LS_START, LS_DATA, LS_PAR, LS_STOP
    } cu_st_t;

endpackage

//--- dv/cu_peer.sv
// Far-side serial device model for the UART core bench.
// Assumes one clock shared with the core and a bit period of divisor+1.
`timescale 1ns/1ps

module cu_peer (
    // Clock and bit timing
    input  wire logic        clk_sys,
    input  wire logic [15:0] divisor,
    // Serial pins seen from the far side
    output logic             rx_serial,
    input  wire logic        tx_serial
);
    logic [7:0] got_q[$];
    int         bad_frames = 0;

    initial rx_serial = 1'b0;

    // =========================================================
    // Sender
    task automatic bit_out(input logic v);
        rx_serial <= v;
        repeat (divisor + 16'h0001) @(posedge clk_sys);
    endtask

    task automatic send_char(input logic [7:0] c, input logic par_flip,
                             input logic stop_v);
        @(posedge clk_sys);
        bit_out(1'b1);
        for (int i = 0; i < 8; i++) begin
            bit_out(c[i]);
        end
        bit_out(^c ^ par_flip);
        bit_out(stop_v);
        bit_out(1'b0);
    endtask

    // =========================================================
    // Receiver, sampling mid-bit and ending at the first stop bit
    initial begin : mon
        logic [9:0] f;
        forever begin
            @(posedge clk_sys);
            if (tx_serial === 1'b1) begin
                repeat ((divisor + 16'h0001) / 2) @(posedge clk_sys);
                for (int i = 0; i < 10; i++) begin
                    repeat (divisor + 16'h0001) @(posedge clk_sys);
                    f[i] = tx_serial;
                end
                got_q.push_back(f[7:0]);
                if (f[8] !== ^f[7:0] || f[9] !== 1'b0) begin
                    bad_frames++;
                end
            end
        end
    end
endmodule

//--- dv/configurable_uart_core_tb_top.sv
// Self-checking bench for the UART core: register tasks plus a far side.
// Assumes the core at 125 MHz with the package build options.
`timescale 1ns/1ps

module configurable_uart_core_tb_top
    import cu_pkg::*;
;
    logic        clk_sys;
    logic        rstn;
    logic        ce;
    logic        rx_serial;
    logic        cts_n;
    cu_req_t     bus_req;
    logic [15:0] bus_rdata;
    logic [15:0] div_val;
    logic [15:0] rd_q;
    logic        bus_rd_avail;
    logic        bus_wr_ready;
    logic        bus_eop;
    logic        irq;
    logic        tx_serial;
    logic        rts_n;
    logic [7:0]  txc[3] = '{8'hA5, 8'h3C, 8'h81};
    int          fail_count = 0;
    int          checks = 0;

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    cu_uart cu_uart_i (
        .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .bus_rd_avail(bus_rd_avail),
        .bus_wr_ready(bus_wr_ready), .bus_eop(bus_eop), .irq(irq),
        .rx_serial(rx_serial), .tx_serial(tx_serial), .cts_n(cts_n),
        .rts_n(rts_n)
    );

    cu_peer cu_peer_i (
        .clk_sys(clk_sys), .divisor(div_val), .rx_serial(rx_serial),
        .tx_serial(tx_serial)
    );

    // =========================================================
    // Tasks
    task automatic test_done();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus_req.wr    <= 1'b1;
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        @(posedge clk_sys);
        bus_req.wr    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [2:0] a);
        @(posedge clk_sys);
        bus_req.rd   <= 1'b1;
        bus_req.addr <= a;
        @(posedge clk_sys);
        bus_req.rd   <= 1'b0;
        @(negedge clk_sys);
        rd_q = bus_rdata;
    endtask

    task automatic wait_rx();
        for (int i = 0; i < 3000; i++) begin
            @(negedge clk_sys);
            if (bus_rd_avail === 1'b1) return;
        end
        fail_count++;
        $display("ERROR receive wait expected 1 seen 0");
        test_done();
    endtask

    task automatic wait_tx(input int n);
        for (int i = 0; i < 5000; i++) begin
            @(negedge clk_sys);
            if (cu_peer_i.got_q.size() >= n) return;
        end
        fail_count++;
        $display("ERROR transmit wait expected %0d seen %0d", n,
                 cu_peer_i.got_q.size());
        test_done();
    endtask

    // =========================================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        cts_n = 1'b1;
        bus_req = '0;
        div_val = FIXED_DIV;
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        reg_rd(A_STATUS);
        chk("status", 16'h0060, rd_q & 16'h00FF);
        reg_rd(A_DIVISOR);
        chk("divisor", FIXED_DIV, rd_q);
        reg_rd(3'h6);
        chk("unmapped", 16'h0000, rd_q);
        reg_wr(A_DIVISOR, 16'h0003);
        div_val <= 16'h0003;
        reg_rd(A_DIVISOR);
        chk("divisor", 16'h0003, rd_q);
        reg_wr(A_CONTROL, 16'h0880);
        reg_rd(A_CONTROL);
        chk("control", 16'h0880, rd_q);
        chk("rts_n", 16'h0000, {15'h0000, rts_n});
        @(posedge clk_sys);
        cts_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        reg_rd(A_STATUS);
        chk("cts", 16'h0C00, rd_q & 16'h0C00);
        reg_wr(A_STATUS, 16'h0000);
        // Three writes fill shifter and buffer; the fourth is refused
        for (int i = 0; i < 3; i++) begin
            reg_wr(A_TXDATA, {8'h00, txc[i]});
        end
        @(negedge clk_sys);
        chk("wr_ready", 16'h0000, {15'h0000, bus_wr_ready});
        reg_wr(A_TXDATA, 16'h00FF);
        wait_tx(3);
        repeat (60) @(posedge clk_sys);
        for (int i = 0; i < 3; i++) begin
            chk("tx char", 16'(txc[i]), 16'(cu_peer_i.got_q[i]));
        end
        chk("tx count", 16'h0003, 16'(cu_peer_i.got_q.size()));
        chk("tx bad frames", 16'h0000, 16'(cu_peer_i.bad_frames));
        reg_rd(A_STATUS);
        chk("status toe", 16'h0070, rd_q & 16'h00FF);
        reg_wr(A_STATUS, 16'h0000);
        cu_peer_i.send_char(8'h5A, 1'b0, 1'b0);
        wait_rx();
        chk("irq", 16'h0001, {15'h0000, irq});
        reg_rd(A_STATUS);
        chk("status rrdy", 16'h00E0, rd_q & 16'h00FF);
        reg_rd(A_RXDATA);
        chk("rxdata", 16'h005A, rd_q);
        chk("rd_avail", 16'h0000, {15'h0000, bus_rd_avail});
        chk("irq", 16'h0000, {15'h0000, irq});
        fork
            cu_peer_i.send_char(8'h44, 1'b0, 1'b0);
            begin
                repeat (20) @(posedge clk_sys);
                reg_rd(A_RXDATA);
                chk("rx hold", 16'h005A, rd_q);
            end
        join
        wait_rx();
        reg_rd(A_RXDATA);
        chk("rxdata", 16'h0044, rd_q);
        cu_peer_i.send_char(8'h11, 1'b1, 1'b0);
        cu_peer_i.send_char(8'h22, 1'b0, 1'b0);
        wait_rx();
        reg_rd(A_STATUS);
        chk("status pe roe", 16'h00E9, rd_q & 16'h00FF);
        reg_rd(A_RXDATA);
        chk("rxdata", 16'h0022, rd_q);
        reg_wr(A_STATUS, 16'h0000);
        reg_rd(A_STATUS);
        chk("status clear", 16'h0060, rd_q & 16'h00FF);
        cu_peer_i.send_char(8'h0F, 1'b0, 1'b1);
        wait_rx();
        reg_rd(A_STATUS);
        chk("status fe", 16'h00E2, rd_q & 16'h00FF);
        reg_rd(A_RXDATA);
        reg_wr(A_STATUS, 16'h0000);
        // Write while frozen is lost
        ce <= 1'b0;
        reg_wr(A_EOPCHAR, 16'h00FF);
        ce <= 1'b1;
        reg_rd(A_EOPCHAR);
        chk("eop char frozen", 16'h0000, rd_q);
        reg_wr(A_EOPCHAR, 16'h00FF);
        reg_rd(A_EOPCHAR);
        chk("eop char", 16'h00FF, rd_q);
        cu_peer_i.send_char(8'hFF, 1'b1, 1'b1);
        wait_rx();
        reg_rd(A_STATUS);
        chk("status brk", 16'h0106, rd_q & 16'h0106);
        chk("eop", 16'h0001, {15'h0000, bus_eop});
        test_done();
    end
endmodule
